// ### rtl/ato_pkg.sv
// ****************************************
// shared constants and types
// ****************************************
package ato_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned OPC_W = 10;
  localparam int unsigned NIB_W = 4;
  localparam int unsigned PORT_W = 3;
  localparam int unsigned PAIR_W = 8;
  localparam int unsigned ICNT_W = 16;

  // instruction codes of the four transfers
  localparam logic [OPC_W-1:0] OPC_LOAD_PORT_LATCH = 10'h029;
  localparam logic [OPC_W-1:0] OPC_LOAD_PAIR_REGISTER = 10'h01a;
  localparam logic [OPC_W-1:0] OPC_LOAD_OUT_STRUCT_FIRST = 10'h228;
  localparam logic [OPC_W-1:0] OPC_LOAD_OUT_STRUCT_SECOND = 10'h229;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_ACC = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_REGB = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_OPCODE = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PORT_LATCH = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_PAIR = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_OUT_FIRST = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_OUT_SECOND = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_ICOUNT = 8'h20;

  // status field positions
  localparam int unsigned ST_CARRY_BIT = 0;
  localparam int unsigned ST_SKIP_BIT = 1;
  localparam int unsigned ST_ILLEGAL_BIT = 2;

  // reset values
  localparam logic [NIB_W-1:0] RST_NIB = 4'h0;
  localparam logic [PORT_W-1:0] RST_PORT = 3'h0;
  localparam logic [PAIR_W-1:0] RST_PAIR = 8'h00;
  localparam logic [OPC_W-1:0] RST_OPC = 10'h000;
  localparam logic [ICNT_W-1:0] RST_ICNT = 16'h0000;

  // decoded instruction kinds
  typedef enum logic [2:0] {
    ATO_OP_NONE,
    ATO_OP_PORT,
    ATO_OP_PAIR,
    ATO_OP_FIRST,
    ATO_OP_SECOND,
    ATO_OP_ILLEGAL
  } ato_op_t;

endpackage

// ### rtl/ato_dec_if.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// opcode to decoder and kind back
// ****************************************
interface ato_dec_if;
  logic [ato_pkg::OPC_W-1:0] opcode;
  ato_pkg::ato_op_t kind;
  modport ctrl (output opcode, input kind);
  modport dec (input opcode, output kind);
endinterface
`default_nettype wire

// ### rtl/ato_decode.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// instruction decoder
// ****************************************
module ato_decode (
  ato_dec_if.dec dec
);

  // map the four transfer words onto their kinds, any other 10-bit word onto illegal
  always_comb begin
    case (dec.opcode)
      ato_pkg::OPC_LOAD_PORT_LATCH: dec.kind = ato_pkg::ATO_OP_PORT;
      ato_pkg::OPC_LOAD_PAIR_REGISTER: dec.kind = ato_pkg::ATO_OP_PAIR;
      ato_pkg::OPC_LOAD_OUT_STRUCT_FIRST: dec.kind = ato_pkg::ATO_OP_FIRST;
      ato_pkg::OPC_LOAD_OUT_STRUCT_SECOND: dec.kind = ato_pkg::ATO_OP_SECOND;
      default: dec.kind = ato_pkg::ATO_OP_ILLEGAL;
    endcase
  end

endmodule // ato_decode
`default_nettype wire

// ### rtl/ato_top.sv
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
// Function
// RULE1 - the port-latch load copies accumulator bits 2..0 into the 3-bit latch, accumulator kept.
// RULE2 - the pair load writes B into bits 7..4 and the accumulator into bits 3..0 at once.
// RULE3 - the first output-structure load copies the 4-bit accumulator into the first register.
// RULE4 - the second output-structure load copies the accumulator into the second register.
// RULE5 - each transfer is one 10-bit word, one cycle, no carry change and no skip.
module ato_top (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [ato_pkg::ADDR_W-1:0] PADDR_IN,
  input wire logic [ato_pkg::DATA_W-1:0] PWDATA_IN,
  output logic [ato_pkg::DATA_W-1:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  output logic [ato_pkg::PORT_W-1:0] PORT_LATCH_OUT,
  output logic [ato_pkg::PAIR_W-1:0] PAIR_REG_OUT,
  output logic [ato_pkg::NIB_W-1:0] OUT_STRUCT_FIRST_OUT,
  output logic [ato_pkg::NIB_W-1:0] OUT_STRUCT_SECOND_OUT
);

  // ****************************************
  // state
  // ****************************************
  logic [ato_pkg::NIB_W-1:0] acc_r, acc_nxt;
  logic [ato_pkg::NIB_W-1:0] regb_r, regb_nxt;
  logic carry_r, carry_nxt;
  logic skip_r, skip_nxt;
  logic illegal_r, illegal_nxt;
  logic [ato_pkg::OPC_W-1:0] opcode_r, opcode_nxt;
  logic exec_r, exec_nxt;
  logic [ato_pkg::PORT_W-1:0] port_latch_r, port_latch_nxt;
  logic [ato_pkg::PAIR_W-1:0] pair_r, pair_nxt;
  logic [ato_pkg::NIB_W-1:0] out_first_r, out_first_nxt;
  logic [ato_pkg::NIB_W-1:0] out_second_r, out_second_nxt;
  logic [ato_pkg::ICNT_W-1:0] icount_r, icount_nxt;
  logic [ato_pkg::DATA_W-1:0] rdata_r, rdata_nxt;
  logic setup_rd;
  logic acc_wr;
  logic mapped;
  ato_pkg::ato_op_t kind;

  // ****************************************
  // decoder
  // ****************************************
  ato_dec_if dif ();

  assign dif.opcode = opcode_r;
  assign kind = dif.kind;

  ato_decode u_decode (
    .dec(dif)
  );

  // ****************************************
  // apb slave
  // ****************************************
  // zero wait states; only access phase writes
  assign PREADY_OUT = 1'b1;
  assign acc_wr = PSEL_IN & PENABLE_IN & PWRITE_IN;
  assign setup_rd = PSEL_IN & ~PENABLE_IN & ~PWRITE_IN;

  // address decode
  always_comb begin
    case (PADDR_IN)
      ato_pkg::OFS_ACC,
      ato_pkg::OFS_REGB,
      ato_pkg::OFS_OPCODE,
      ato_pkg::OFS_PORT_LATCH,
      ato_pkg::OFS_PAIR,
      ato_pkg::OFS_OUT_FIRST,
      ato_pkg::OFS_OUT_SECOND,
      ato_pkg::OFS_STATUS,
      ato_pkg::OFS_ICOUNT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~mapped;

  // read data captured in the setup cycle
  always_comb begin
    rdata_nxt = rdata_r;
    if (setup_rd) begin
      rdata_nxt = '0;
      case (PADDR_IN)
        ato_pkg::OFS_ACC: rdata_nxt[ato_pkg::NIB_W-1:0] = acc_r;
        ato_pkg::OFS_REGB: rdata_nxt[ato_pkg::NIB_W-1:0] = regb_r;
        ato_pkg::OFS_OPCODE: rdata_nxt[ato_pkg::OPC_W-1:0] = opcode_r;
        ato_pkg::OFS_PORT_LATCH: rdata_nxt[ato_pkg::PORT_W-1:0] = port_latch_r;
        ato_pkg::OFS_PAIR: rdata_nxt[ato_pkg::PAIR_W-1:0] = pair_r;
        ato_pkg::OFS_OUT_FIRST: rdata_nxt[ato_pkg::NIB_W-1:0] = out_first_r;
        ato_pkg::OFS_OUT_SECOND: rdata_nxt[ato_pkg::NIB_W-1:0] = out_second_r;
        ato_pkg::OFS_STATUS: begin
          rdata_nxt[ato_pkg::ST_CARRY_BIT] = carry_r;
          rdata_nxt[ato_pkg::ST_SKIP_BIT] = skip_r;
          rdata_nxt[ato_pkg::ST_ILLEGAL_BIT] = illegal_r;
        end
        ato_pkg::OFS_ICOUNT: rdata_nxt[ato_pkg::ICNT_W-1:0] = icount_r;
        default: rdata_nxt = '0;
      endcase
    end
  end

  // ****************************************
  // software writes and execution
  // ****************************************
  // one opcode write starts one execution cycle
  always_comb begin
    acc_nxt = acc_r;
    regb_nxt = regb_r;
    carry_nxt = carry_r;
    skip_nxt = skip_r;
    illegal_nxt = illegal_r;
    opcode_nxt = opcode_r;
    exec_nxt = 1'b0;
    port_latch_nxt = port_latch_r;
    pair_nxt = pair_r;
    out_first_nxt = out_first_r;
    out_second_nxt = out_second_r;
    icount_nxt = icount_r;
    if (acc_wr) begin
      case (PADDR_IN)
        ato_pkg::OFS_ACC: acc_nxt = PWDATA_IN[ato_pkg::NIB_W-1:0];
        ato_pkg::OFS_REGB: regb_nxt = PWDATA_IN[ato_pkg::NIB_W-1:0];
        ato_pkg::OFS_OPCODE: begin
          opcode_nxt = PWDATA_IN[ato_pkg::OPC_W-1:0]; // RULE5
          exec_nxt = 1'b1;
        end
        ato_pkg::OFS_STATUS: begin
          carry_nxt = PWDATA_IN[ato_pkg::ST_CARRY_BIT];
          if (PWDATA_IN[ato_pkg::ST_ILLEGAL_BIT]) begin
            illegal_nxt = 1'b0; // write one to clear
          end
        end
        default: acc_nxt = acc_r;
      endcase
    end
    if (exec_r) begin
      skip_nxt = 1'b0; // RULE5
      icount_nxt = icount_r + 16'h0001;
      case (kind)
        ato_pkg::ATO_OP_PORT: port_latch_nxt = acc_r[ato_pkg::PORT_W-1:0]; // RULE1
        ato_pkg::ATO_OP_PAIR: pair_nxt = {regb_r, acc_r}; // RULE2
        ato_pkg::ATO_OP_FIRST: out_first_nxt = acc_r; // RULE3
        ato_pkg::ATO_OP_SECOND: out_second_nxt = acc_r; // RULE4
        ato_pkg::ATO_OP_ILLEGAL: illegal_nxt = 1'b1; // set wins over clear
        default: icount_nxt = icount_r;
      endcase
    end
  end

  // register all state
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      acc_r <= ato_pkg::RST_NIB;
      regb_r <= ato_pkg::RST_NIB;
      carry_r <= 1'b0;
      skip_r <= 1'b0;
      illegal_r <= 1'b0;
      opcode_r <= ato_pkg::RST_OPC;
      exec_r <= 1'b0;
      port_latch_r <= ato_pkg::RST_PORT;
      pair_r <= ato_pkg::RST_PAIR;
      out_first_r <= ato_pkg::RST_NIB;
      out_second_r <= ato_pkg::RST_NIB;
      icount_r <= ato_pkg::RST_ICNT;
      rdata_r <= '0;
    end else begin
      acc_r <= acc_nxt;
      regb_r <= regb_nxt;
      carry_r <= carry_nxt;
      skip_r <= skip_nxt;
      illegal_r <= illegal_nxt;
      opcode_r <= opcode_nxt;
      exec_r <= exec_nxt;
      port_latch_r <= port_latch_nxt;
      pair_r <= pair_nxt;
      out_first_r <= out_first_nxt;
      out_second_r <= out_second_nxt;
      icount_r <= icount_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign PRDATA_OUT = rdata_r;
  assign PORT_LATCH_OUT = port_latch_r;
  assign PAIR_REG_OUT = pair_r;
  assign OUT_STRUCT_FIRST_OUT = out_first_r;
  assign OUT_STRUCT_SECOND_OUT = out_second_r;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);

  // port latch takes acc low bits, acc kept
  property p_port_latch;
    exec_r && kind == ato_pkg::ATO_OP_PORT |=>
      PORT_LATCH_OUT == $past(acc_r[ato_pkg::PORT_W-1:0]) && $stable(acc_r)
      && $stable(PAIR_REG_OUT);
  endproperty
  a_port_latch: assert property (p_port_latch) else $error("port latch load wrong"); // RULE1

  // pair register gets b high, acc low
  property p_pair_load;
    exec_r && kind == ato_pkg::ATO_OP_PAIR |=>
      PAIR_REG_OUT[7:4] == $past(regb_r) && PAIR_REG_OUT[3:0] == $past(acc_r);
  endproperty
  a_pair_load: assert property (p_pair_load) else $error("pair load wrong"); // RULE2

  // first structure register gets acc
  property p_first_load;
    exec_r && kind == ato_pkg::ATO_OP_FIRST |=>
      OUT_STRUCT_FIRST_OUT == $past(acc_r) && $stable(OUT_STRUCT_SECOND_OUT);
  endproperty
  a_first_load: assert property (p_first_load) else $error("first struct load wrong"); // RULE3

  // second structure register gets acc
  property p_second_load;
    exec_r && kind == ato_pkg::ATO_OP_SECOND |=>
      OUT_STRUCT_SECOND_OUT == $past(acc_r) && $stable(OUT_STRUCT_FIRST_OUT);
  endproperty
  a_second_load: assert property (p_second_load) else $error("second struct load wrong"); // RULE4

  // opcode write runs for one cycle, carry untouched, skip clear, count up by one
  property p_one_cycle;
    acc_wr && PADDR_IN == ato_pkg::OFS_OPCODE |=>
      exec_r ##1 (!exec_r && $stable(carry_r) && !skip_r
      && icount_r == $past(icount_r) + 16'h0001);
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("execution not one cycle"); // RULE5

  // main scenarios
  c_port: cover property (exec_r && kind == ato_pkg::ATO_OP_PORT);
  c_pair: cover property (exec_r && kind == ato_pkg::ATO_OP_PAIR);
  c_both_struct: cover property (exec_r && kind == ato_pkg::ATO_OP_FIRST ##[2:60]
    exec_r && kind == ato_pkg::ATO_OP_SECOND);
  c_illegal: cover property (exec_r && kind == ato_pkg::ATO_OP_ILLEGAL);

endmodule // ato_top
`default_nettype wire

// ### testbench/tb.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// bench for the accumulator transfers
// ****************************************
module tb;
  logic clk, rst, psel, pen, pwr, pready, pslverr, cy;
  logic [ato_pkg::ADDR_W-1:0] paddr;
  logic [ato_pkg::DATA_W-1:0] pwdata, prdata, rnd;
  logic [ato_pkg::PORT_W-1:0] port_q, e_port;
  logic [ato_pkg::PAIR_W-1:0] pair_q, e_pair;
  logic [ato_pkg::NIB_W-1:0] first_q, second_q, e_first, e_second, acc, rb;
  logic [ato_pkg::OPC_W-1:0] op;
  logic [15:0] e_cnt;
  logic [32:0] exp_q[$];
  int n_errors, check_count, cycles;
  localparam logic [9:0] CODES [4] = '{ato_pkg::OPC_LOAD_PORT_LATCH,
    ato_pkg::OPC_LOAD_PAIR_REGISTER, ato_pkg::OPC_LOAD_OUT_STRUCT_FIRST,
    ato_pkg::OPC_LOAD_OUT_STRUCT_SECOND};

  ato_top ato_top_inst (.CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .PORT_LATCH_OUT(port_q),
    .PAIR_REG_OUT(pair_q), .OUT_STRUCT_FIRST_OUT(first_q), .OUT_STRUCT_SECOND_OUT(second_q));

  // 50 mhz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // one line per mismatch
  task automatic report(input logic [32:0] got, input logic [32:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // read word plus error flag
  task automatic cmp_rd(input logic [32:0] got, input logic [32:0] exp);
    report(got, exp);
  endtask

  // output pins
  task automatic cmp_out(input logic [31:0] got, input logic [31:0] exp);
    report({1'b0, got}, {1'b0, exp});
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ****************************************
  // apb master
  // ****************************************
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // note the expected answer, then read
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic e);
    exp_q.push_back({e, d});
    apb(1'b0, a, 32'h0);
  endtask

  // watcher takes the oldest note at each completed read
  always @(posedge clk) begin
    if (psel === 1'b1 && pen === 1'b1 && pwr === 1'b0 && pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        cmp_rd({pslverr, prdata}, 33'h1ffffffff);
      end else begin
        cmp_rd({pslverr, prdata}, exp_q.pop_front());
      end
    end
  end

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  // all outputs against the model
  task automatic check_all;
    cmp_out(32'(port_q), 32'(e_port));
    cmp_out(32'(pair_q), 32'(e_pair));
    cmp_out(32'(first_q), 32'(e_first));
    cmp_out(32'(second_q), 32'(e_second));
    rd(ato_pkg::OFS_PAIR, 32'(e_pair), 1'b0);
    rd(ato_pkg::OFS_ICOUNT, 32'(e_cnt), 1'b0);
    rd(ato_pkg::OFS_ACC, 32'(acc), 1'b0);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rnd = 32'h3c34a65e;
    n_errors = 0;
    check_count = 0;
    cycles = 0;
    {e_port, e_pair, e_first, e_second, e_cnt, acc, rb, cy} = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // reset values, then unmapped places
    for (int i = 0; i < 9; i++) rd(8'(i * 4), 32'h0, 1'b0);
    rd(8'h24, 32'h0, 1'b1);
    rd(8'h02, 32'h0, 1'b1);
    // random transfers over all four codes
    for (int i = 0; i < 40; i++) begin
      rnd = lfsr(rnd);
      acc = rnd[3:0];
      rb = rnd[7:4];
      cy = rnd[8];
      op = CODES[rnd[10:9]];
      wr(ato_pkg::OFS_ACC, 32'(acc));
      wr(ato_pkg::OFS_REGB, 32'(rb));
      wr(ato_pkg::OFS_STATUS, 32'(cy));
      wr(ato_pkg::OFS_OPCODE, 32'(op));
      case (rnd[10:9])
        2'd0: e_port = acc[2:0];
        2'd1: e_pair = {rb, acc};
        2'd2: e_first = acc;
        default: e_second = acc;
      endcase
      e_cnt++;
      repeat (2) @(posedge clk);
      #1;
      check_all();
      rd(ato_pkg::OFS_STATUS, 32'(cy), 1'b0);
    end
    // unknown code sets the sticky flag, still counted, no target touched
    wr(ato_pkg::OFS_OPCODE, 32'h3ff);
    e_cnt++;
    repeat (2) @(posedge clk);
    #1;
    check_all();
    rd(ato_pkg::OFS_STATUS, 32'h4 | 32'(cy), 1'b0);
    wr(ato_pkg::OFS_STATUS, 32'h4 | 32'(cy));
    rd(ato_pkg::OFS_STATUS, 32'(cy), 1'b0);
    // writes to read-only or unmapped places are ignored
    wr(ato_pkg::OFS_PAIR, 32'hff);
    wr(8'h24, 32'hf);
    check_all();
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
